// [hw/tmrb_channel.v]
// one capture/compare/pwm channel of the second timer unit
// assumes counter, tick and wrap pulses come from the same clock
`timescale 1ns/1ps
module tmrb_channel (
  input wire i_clk,
  input wire i_rst,
  input wire i_pin,
  input wire i_tick,
  input wire i_ovf,
  input wire [15:0] i_cnt,
  input wire [15:0] i_cmp_val,
  input wire i_cap_hold,
  input wire i_cmp_hold,
  input wire i_halt,
  input wire i_enable,
  input wire i_buffered,
  input wire i_msa,
  input wire [1:0] i_els,
  input wire i_tov,
  input wire i_max,
  output wire o_capture,
  output wire o_match,
  output reg o_pin,
  output wire o_pin_oe
);
  reg s1;
  reg s2;
  reg s3;
  reg filt;
  reg max_eff;
  wire els_on = (i_els != 2'h0);
  wire cap_mode = i_enable && els_on && !i_buffered && !i_msa;
  wire cmp_mode = i_enable && els_on && (i_buffered || i_msa);
  wire agree = (s2 == s3);
  wire rise = agree && s3 && !filt;
  wire fall = agree && !s3 && filt;
  wire edge_hit = (i_els == 2'h1) ? rise :
                  (i_els == 2'h2) ? fall : (rise || fall);

  // pin synchroniser and glitch filter
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      filt <= 1'b0;
    end else begin
      s1 <= i_pin;
      s2 <= s1;
      s3 <= s2;
      if (agree)
        filt <= s3;
    end
  end

  // capture hold while high byte read
  assign o_capture = cap_mode && !i_halt && !i_cap_hold && edge_hit;
  assign o_match = cmp_mode && i_tick && !i_cmp_hold && (i_cnt == i_cmp_val);
  // pin driven only in active mode
  assign o_pin_oe = cmp_mode;

  // output level, overflow toggle and full duty
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin <= 1'b1;
      max_eff <= 1'b0;
    end else begin
      if (i_ovf)
        max_eff <= i_max;
      if (!els_on) begin
        o_pin <= !i_msa;
      end else if (cmp_mode) begin
        if (i_ovf && i_tov) begin
          o_pin <= !o_pin;
        end else if (max_eff && !i_tov) begin
          o_pin <= (i_els == 2'h3) ? 1'b0 : 1'b1;
        end else if (o_match) begin
          case (i_els)
            2'h1: o_pin <= !o_pin;
            2'h2: o_pin <= 1'b0;
            default: o_pin <= 1'b1;
          endcase
        end
      end
    end
  end
endmodule

// [hw/tmrb_regs.vh]
// register map and field layout of the second timer unit
// assumes word-aligned apb access, byte address = 4 * index
`ifndef TMRB_REGS_VH
`define TMRB_REGS_VH
// register indices
`define TMRB_IDX_CTRL 8'h51
`define TMRB_IDX_CNTH 8'h52
`define TMRB_IDX_CNTL 8'h53
`define TMRB_IDX_MODH 8'h54
`define TMRB_IDX_MODL 8'h55
`define TMRB_IDX_SC0 8'h56
`define TMRB_IDX_CH0H 8'h57
`define TMRB_IDX_CH0L 8'h58
`define TMRB_IDX_SC1 8'h59
`define TMRB_IDX_CH1H 8'h5a
`define TMRB_IDX_CH1L 8'h5b
// timer_main_control fields
`define TMRB_CTRL_FLAG 7
`define TMRB_CTRL_IE 6
`define TMRB_CTRL_HALT 5
`define TMRB_CTRL_CLR 4
`define TMRB_CTRL_PS_HI 2
`define TMRB_CTRL_PS_LO 0
// channel control/status fields
`define TMRB_SC_FLAG 7
`define TMRB_SC_IE 6
`define TMRB_SC_MSB 5
`define TMRB_SC_MSA 4
`define TMRB_SC_ELSB 3
`define TMRB_SC_ELSA 2
`define TMRB_SC_TOV 1
`define TMRB_SC_MAX 0
// reset values
`define TMRB_RST_HALT 1'b1
`define TMRB_RST_PS 3'h0
`define TMRB_RST_MOD 16'hffff
`define TMRB_RST_CNT 16'h0000
// prescaler code that selects no clock
`define TMRB_PS_INVALID 3'h7
`endif

// [hw/tmrb_top.v]
// second timer unit: prescaler, wrap counter, two channels, apb slave
// assumes apb master on i_clk; channel pins come from outside the domain
`timescale 1ns/1ps
`include "tmrb_regs.vh"

// Overview of operation
// - halt plus clear holds counter at zero
// - divider select picks bus clock divide
// - high count read latches low byte
// - count bytes are read only
// - count zero after reset or clear
// - match with limit sets flag, restarts
// - limit high write blocks wrap flag
// - reset sets limit to all ones
// - channel flag on capture or match
// - flag clear by read then write zero
// - per channel irq enable gates request
// - buffered select only in channel zero
// - mode a picks compare or level
// - select 00 releases pin to port
// - capture edge chosen by select bits
// - compare action toggle, low or high
// - wrap toggle flips pin on overflow
// - overflow beats compare when coincident
// - full duty force from next period
// - high value read blocks captures
// - high value write blocks matches
// - value holds capture or compare value
// - halt bit stops counting, set by reset
// - clear bit zeroes counter and prescaler
module tmrb_top (
  input wire i_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  output reg [31:0] o_prdata,
  output wire o_pready,
  output wire o_pslverr,
  input wire [1:0] i_chan_pin,
  output wire [1:0] o_chan_pin,
  output wire [1:0] o_chan_pin_oe,
  output wire [1:0] o_chan_irq,
  output wire o_wrap_irq
);
  // main control and counter state
  reg halt;
  reg wrap_ie;
  reg [2:0] ps;
  reg wrap_flag;
  reg wrap_arm;
  reg [15:0] cnt;
  reg [5:0] presc;
  reg [15:0] modv;
  reg mod_pend;
  reg [7:0] cnt_lat;
  reg cnt_latd;
  // channel state, bit k is channel k
  reg [1:0] flag;
  reg [1:0] arm;
  reg [1:0] ie;
  reg msb0;
  reg [1:0] msa;
  reg [1:0] elsb;
  reg [1:0] elsa;
  reg [1:0] tov;
  reg [1:0] maxf;
  reg [1:0] cap_hold;
  reg [1:0] cmp_hold;
  reg [15:0] val0;
  reg [15:0] val1;
  reg buf_sel;
  reg buf_new;
  integer k;

  // apb decode
  wire [7:0] idx = i_paddr[9:2];
  wire acc = i_psel && i_penable;
  wire wr = acc && i_pwrite;
  wire rd = acc && !i_pwrite;
  wire [7:0] wd = i_pwdata[7:0];
  wire mapped = (i_paddr[1:0] == 2'h0) && (i_paddr[11:10] == 2'h0) &&
                (idx >= `TMRB_IDX_CTRL) && (idx <= `TMRB_IDX_CH1L);
  wire wr_ctrl = wr && mapped && (idx == `TMRB_IDX_CTRL);
  wire wr_modh = wr && mapped && (idx == `TMRB_IDX_MODH);
  wire wr_modl = wr && mapped && (idx == `TMRB_IDX_MODL);
  wire rd_cnth = rd && mapped && (idx == `TMRB_IDX_CNTH);
  wire rd_cntl = rd && mapped && (idx == `TMRB_IDX_CNTL);
  wire rd_ctrl = rd && mapped && (idx == `TMRB_IDX_CTRL);
  wire [1:0] wr_sc;
  wire [1:0] rd_sc;
  wire [1:0] wr_vh;
  wire [1:0] wr_vl;
  wire [1:0] rd_vh;
  wire [1:0] rd_vl;
  assign wr_sc = {wr && mapped && (idx == `TMRB_IDX_SC1),
                  wr && mapped && (idx == `TMRB_IDX_SC0)};
  assign rd_sc = {rd && mapped && (idx == `TMRB_IDX_SC1),
                  rd && mapped && (idx == `TMRB_IDX_SC0)};
  assign wr_vh = {wr && mapped && (idx == `TMRB_IDX_CH1H),
                  wr && mapped && (idx == `TMRB_IDX_CH0H)};
  assign wr_vl = {wr && mapped && (idx == `TMRB_IDX_CH1L),
                  wr && mapped && (idx == `TMRB_IDX_CH0L)};
  assign rd_vh = {rd && mapped && (idx == `TMRB_IDX_CH1H),
                  rd && mapped && (idx == `TMRB_IDX_CH0H)};
  assign rd_vl = {rd && mapped && (idx == `TMRB_IDX_CH1L),
                  rd && mapped && (idx == `TMRB_IDX_CH0L)};
  assign o_pready = 1'b1;
  assign o_pslverr = acc && !mapped;

  wire [6:0] div_mask = (7'h01 << ps) - 7'h01;
  wire tick = !halt && (ps != `TMRB_PS_INVALID) &&
              ((presc & div_mask[5:0]) == div_mask[5:0]);
  wire clr_cmd = wr_ctrl && wd[`TMRB_CTRL_CLR];
  wire wrap_ev = tick && (cnt == modv) && !clr_cmd;
  // wrap flag suppressed while limit split
  wire wrap_set = wrap_ev && !mod_pend;

  // channel wiring; ch1 parked while linked into buffered pair
  wire [1:0] cap_ev;
  wire [1:0] match_ev;
  wire [1:0] ev = cap_ev | match_ev;
  wire [1:0] pin_q;
  wire [1:0] pin_oe;
  wire [31:0] cmp_val = {val1, (msb0 && buf_sel) ? val1 : val0};
  wire [1:0] cmp_blk = {cmp_hold[1],
                        (msb0 && buf_sel) ? cmp_hold[1] : cmp_hold[0]};
  wire [1:0] ch_en = {!msb0, 1'b1};
  wire [1:0] buf_md = {1'b0, msb0};

  // one instance per channel
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : gch
      tmrb_channel u_ch (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_pin(i_chan_pin[g]),
        .i_tick(tick),
        .i_ovf(wrap_ev),
        .i_cnt(cnt),
        .i_cmp_val(cmp_val[16*g+15:16*g]),
        .i_cap_hold(cap_hold[g]),
        .i_cmp_hold(cmp_blk[g]),
        .i_halt(halt),
        .i_enable(ch_en[g]),
        .i_buffered(buf_md[g]),
        .i_msa(msa[g]),
        .i_els({elsb[g], elsa[g]}),
        .i_tov(tov[g]),
        .i_max(maxf[g]),
        .o_capture(cap_ev[g]),
        .o_match(match_ev[g]),
        .o_pin(pin_q[g]),
        .o_pin_oe(pin_oe[g])
      );
    end
  endgenerate

  assign o_chan_pin = pin_q;
  assign o_chan_pin_oe = pin_oe;
  assign o_chan_irq = flag & ie;
  assign o_wrap_irq = wrap_flag && wrap_ie;

  // prescaler, counter and main control
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      halt <= `TMRB_RST_HALT;
      wrap_ie <= 1'b0;
      ps <= `TMRB_RST_PS;
      cnt <= `TMRB_RST_CNT;
      presc <= 6'h00;
      wrap_flag <= 1'b0;
      wrap_arm <= 1'b0;
      modv <= `TMRB_RST_MOD;
      mod_pend <= 1'b0;
      cnt_lat <= 8'h00;
      cnt_latd <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        halt <= wd[`TMRB_CTRL_HALT];
        wrap_ie <= wd[`TMRB_CTRL_IE];
        ps <= wd[`TMRB_CTRL_PS_HI:`TMRB_CTRL_PS_LO];
      end
      if (clr_cmd) begin
        cnt <= 16'h0000;
        presc <= 6'h00;
      end else if (!halt) begin
        presc <= presc + 6'h01;
        if (wrap_ev)
          cnt <= 16'h0000;
        else if (tick)
          cnt <= cnt + 16'h0001;
      end
      // wrap flag: set wins over a pending clear
      if (rd_ctrl && wrap_flag)
        wrap_arm <= 1'b1;
      if (wrap_set) begin
        wrap_flag <= 1'b1;
        wrap_arm <= 1'b0;
      end else if (wr_ctrl) begin
        if (!wd[`TMRB_CTRL_FLAG] && wrap_arm)
          wrap_flag <= 1'b0;
        wrap_arm <= 1'b0;
      end
      if (wr_modh) begin
        modv[15:8] <= wd;
        mod_pend <= 1'b1;
      end
      if (wr_modl) begin
        modv[7:0] <= wd;
        mod_pend <= 1'b0;
      end
      // low byte held after high read
      if (rd_cnth && !cnt_latd) begin
        cnt_lat <= cnt[7:0];
        cnt_latd <= 1'b1;
      end else if (rd_cntl) begin
        cnt_latd <= 1'b0;
      end
    end
  end

  // channel control, flags and value registers
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      flag <= 2'h0;
      arm <= 2'h0;
      ie <= 2'h0;
      msb0 <= 1'b0;
      msa <= 2'h0;
      elsb <= 2'h0;
      elsa <= 2'h0;
      tov <= 2'h0;
      maxf <= 2'h0;
      cap_hold <= 2'h0;
      cmp_hold <= 2'h0;
      // values have no defined reset, zero chosen
      val0 <= 16'h0000;
      val1 <= 16'h0000;
      buf_sel <= 1'b0;
      buf_new <= 1'b0;
    end else begin
      for (k = 0; k < 2; k = k + 1) begin
        if (rd_sc[k] && flag[k])
          arm[k] <= 1'b1;
        // clear only after armed read, event wins
        if (ev[k]) begin
          flag[k] <= 1'b1;
          arm[k] <= 1'b0;
        end else if (wr_sc[k]) begin
          if (!wd[`TMRB_SC_FLAG] && arm[k])
            flag[k] <= 1'b0;
          arm[k] <= 1'b0;
        end
        if (wr_sc[k]) begin
          ie[k] <= wd[`TMRB_SC_IE];
          msa[k] <= wd[`TMRB_SC_MSA];
          elsb[k] <= wd[`TMRB_SC_ELSB];
          elsa[k] <= wd[`TMRB_SC_ELSA];
          tov[k] <= wd[`TMRB_SC_TOV];
          maxf[k] <= wd[`TMRB_SC_MAX];
        end
        // high read in capture mode holds
        if (rd_vh[k] && !msa[k] && !(k == 0 && msb0))
          cap_hold[k] <= 1'b1;
        else if (rd_vl[k])
          cap_hold[k] <= 1'b0;
        if (wr_vh[k])
          cmp_hold[k] <= 1'b1;
        else if (wr_vl[k])
          cmp_hold[k] <= 1'b0;
      end
      // buffered select lives in channel zero only
      if (wr_sc[0])
        msb0 <= wd[`TMRB_SC_MSB];
      // capture stores count, writes set compare
      if (cap_ev[0])
        val0 <= cnt;
      else if (wr_vh[0])
        val0[15:8] <= wd;
      else if (wr_vl[0])
        val0[7:0] <= wd;
      if (cap_ev[1])
        val1 <= cnt;
      else if (wr_vh[1])
        val1[15:8] <= wd;
      else if (wr_vl[1])
        val1[7:0] <= wd;
      // buffered pair: swap to the freshly written set at wrap
      if (!msb0) begin
        buf_sel <= 1'b0;
        buf_new <= 1'b0;
      end else if (wrap_ev && buf_new) begin
        buf_sel <= !buf_sel;
        buf_new <= 1'b0;
      end else if ((buf_sel && wr_vl[0]) || (!buf_sel && wr_vl[1])) begin
        buf_new <= 1'b1;
      end
    end
  end

  // read data captured in the setup cycle
  always @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_prdata <= 32'h00000000;
    end else if (i_psel && !i_penable) begin
      o_prdata <= 32'h00000000;
      if (idx == `TMRB_IDX_CTRL)
        o_prdata[7:0] <= {wrap_flag, wrap_ie, halt, 2'h0, ps};
      else if (idx == `TMRB_IDX_CNTH)
        o_prdata[7:0] <= cnt[15:8];
      else if (idx == `TMRB_IDX_CNTL)
        o_prdata[7:0] <= cnt_latd ? cnt_lat : cnt[7:0];
      else if (idx == `TMRB_IDX_MODH)
        o_prdata[7:0] <= modv[15:8];
      else if (idx == `TMRB_IDX_MODL)
        o_prdata[7:0] <= modv[7:0];
      else if (idx == `TMRB_IDX_SC0)
        o_prdata[7:0] <= {flag[0], ie[0], msb0, msa[0], elsb[0], elsa[0],
                          tov[0], maxf[0]};
      else if (idx == `TMRB_IDX_CH0H)
        o_prdata[7:0] <= val0[15:8];
      else if (idx == `TMRB_IDX_CH0L)
        o_prdata[7:0] <= val0[7:0];
      else if (idx == `TMRB_IDX_SC1)
        o_prdata[7:0] <= {flag[1], ie[1], 1'b0, msa[1], elsb[1], elsa[1],
                          tov[1], maxf[1]};
      else if (idx == `TMRB_IDX_CH1H)
        o_prdata[7:0] <= val1[15:8];
      else if (idx == `TMRB_IDX_CH1L)
        o_prdata[7:0] <= val1[7:0];
    end
  end
  // count registers have no write path
endmodule

// [tb/tbccp_monitor.sv]
// checker on the apb and channel ports of the second timer unit
// assumes aligned byte addresses, index = paddr[9:2]
`timescale 1ns/1ps
module tbccp_monitor (
  input wire i_clk,
  input wire i_rst,
  input wire i_psel,
  input wire i_penable,
  input wire i_pwrite,
  input wire [11:0] i_paddr,
  input wire [31:0] i_pwdata,
  input wire [31:0] o_prdata,
  input wire o_pready,
  input wire o_pslverr,
  input wire [1:0] i_chan_pin,
  input wire [1:0] o_chan_pin,
  input wire [1:0] o_chan_pin_oe,
  input wire [1:0] o_chan_irq,
  input wire o_wrap_irq
);
  // access phase decode
  wire acc = i_psel & i_penable & (i_paddr[11:10] == 2'b00)
    & (i_paddr[1:0] == 2'b00);
  wire [7:0] x = i_paddr[9:2];
  wire rd = acc & ~i_pwrite;
  wire wr = acc & i_pwrite;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_cnt_write_ok: assert property (wr && x == 8'h52 |-> !o_pslverr)
    else $error("count write flagged");
  a_clr_reads_zero: assert property (rd && x == 8'h51
    |-> !o_prdata[4])
    else $error("clear bit read as one");
  a_ch1_no_buf: assert property (rd && x == 8'h59 |-> !o_prdata[5])
    else $error("channel 1 buffered bit set");
  a_preset_no_oe: assert property (wr && x == 8'h56
    && i_pwdata[3:2] == 2'b00 |=> !o_chan_pin_oe[0])
    else $error("preset channel drives pin");
  a_cmp_drives: assert property (wr && x == 8'h56
    && i_pwdata[5:4] == 2'b01 && i_pwdata[3:2] != 2'b00 |=> o_chan_pin_oe[0])
    else $error("compare channel not driving");
  a_ie_gates: assert property (rd && x == 8'h56
    && !o_prdata[6] |-> !o_chan_irq[0])
    else $error("irq without enable");
  a_irq_follows: assert property (rd && x == 8'h56
    && o_prdata[7:6] == 2'b11 |-> o_chan_irq[0])
    else $error("irq missing");
  a_one_no_clear: assert property (wr && x == 8'h56
    && i_pwdata[7:6] == 2'b11 && o_chan_irq[0] |=> o_chan_irq[0])
    else $error("flag cleared by one");
  a_err_unmapped: assert property (acc && x == 8'h00 |-> o_pslverr)
    else $error("unmapped access accepted");
endmodule
bind tmrb_top tbccp_monitor i_mon (.i_clk(i_clk), .i_rst(i_rst),
  .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
  .o_pready(o_pready), .o_pslverr(o_pslverr), .i_chan_pin(i_chan_pin),
  .o_chan_pin(o_chan_pin), .o_chan_pin_oe(o_chan_pin_oe),
  .o_chan_irq(o_chan_irq), .o_wrap_irq(o_wrap_irq));

// [tb/tbccp_pins.sv]
// far side of the channel pins: port logic and the pin wires
// assumes the bench sets the port level; an enabled channel wins
`timescale 1ns/1ps
module tbccp_pins (
  input wire [1:0] i_port,
  input wire [1:0] i_drive,
  input wire [1:0] i_oe,
  output wire [1:0] o_wire
);
  assign o_wire = (i_oe & i_drive) | (~i_oe & i_port);
endmodule

// [tb/timer_b_capture_compare_pwm_bench.sv]
// self-checking bench for the second timer unit
// assumes tmrb_top, the pin model and the bound monitor
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin \
  num_errors++; $display("Error %0t got %h exp %h", $time, g, e); end end
module timer_b_capture_compare_pwm_bench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rv;
  logic pready, pslverr, wirq;
  logic [1:0] port = 2'h0;
  logic [1:0] pin, cpin, oe, irq;
  logic [7:0] la;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  int k;
  // rows: write flag, index, data or expected read, wait cycles
  logic [31:0] rows [24] = '{
    32'h00512000, 32'h00520000, 32'h00530000, 32'h0054ff00,
    32'h0055ff00, 32'h00560000, 32'h00590000, 32'h00000000,
    32'h01525500, 32'h00520000, 32'h01592000, 32'h00590000,
    32'h01510014, 32'h0151300a, 32'h00520000, 32'h00530000,
    32'h00512000, 32'h01540000, 32'h01550400, 32'h01540000,
    32'h01510028, 32'h00510000, 32'h01550428, 32'h00518000
  };
  // pwm cases: control, low value byte, high cycles out of 100
  logic [23:0] pw [6] = '{24'h1c0364, 24'h180300, 24'h140332,
    24'h1a0328, 24'h1e0932, 24'h190364};

  // clock
  initial begin
    forever #2 clk = ~clk;
  end

  tmrb_top i_dut (.i_clk(clk), .i_rst(rst), .i_psel(psel),
    .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .i_chan_pin(pin), .o_chan_pin(cpin),
    .o_chan_pin_oe(oe), .o_chan_irq(irq), .o_wrap_irq(wirq));
  tbccp_pins i_pins (.i_port(port), .i_drive(cpin), .i_oe(oe),
    .o_wire(pin));

  // verdict and end of run
  task test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // cut a hang short
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 15000) begin
      num_errors++;
      test_done();
    end
  end

  // one apb transfer, read data left in rv
  task apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rv = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // wait, then stop where outputs have settled
  task settle(input int c);
    repeat (c) @(posedge clk);
    @(negedge clk);
  endtask

  // main sequence
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      apb(rows[i][24], rows[i][23:16], rows[i][15:8]);
      if (!rows[i][24]) `CHK(rv[7:0], rows[i][15:8])
      repeat (rows[i][7:0]) @(posedge clk);
    end
    // wrap flag still set from the last row: enable its request
    apb(1'b1, 8'h51, 8'hc0);
    settle(0);
    `CHK(wirq, 1'b1)
    $display("register rows done");
    // each divider code: about sixteen ticks a window, none for 111
    apb(1'b1, 8'h54, 8'hff);
    apb(1'b1, 8'h55, 8'hff);
    for (int n = 0; n < 8; n++) begin
      apb(1'b1, 8'h51, 8'h30);
      apb(1'b1, 8'h51, 8'(n));
      repeat ((16 << n) - 2) @(posedge clk);
      apb(1'b1, 8'h51, 8'h20);
      apb(1'b0, 8'h52, 8'h00);
      `CHK(rv[7:0], 8'h00)
      apb(1'b0, 8'h53, 8'h00);
      k = rv[7:0];
      `CHK(n == 7 ? k == 0 : k >= 15 && k <= 17, 1'b1)
    end
    $display("divider test done");
    // a second high read must not relatch the low byte
    apb(1'b1, 8'h51, 8'h30);
    apb(1'b1, 8'h51, 8'h00);
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h52, 8'h00);
    apb(1'b0, 8'h52, 8'h00);
    apb(1'b1, 8'h51, 8'h20);
    apb(1'b0, 8'h53, 8'h00);
    la = rv[7:0];
    apb(1'b0, 8'h52, 8'h00);
    apb(1'b0, 8'h53, 8'h00);
    k = rv[7:0] - la;
    `CHK(k >= 5 && k <= 7, 1'b1)
    $display("count latch test done");
    // capture edges per select code, with the flag clear sequence
    apb(1'b1, 8'h51, 8'h00);
    for (int n = 1; n < 4; n++) begin
      apb(1'b0, 8'h56, 8'h00);
      apb(1'b1, 8'h56, 8'h40 | 8'(n << 2));
      port[0] <= 1'b1;
      settle(8);
      `CHK(irq[0], n[0])
      apb(1'b1, 8'h56, 8'hc0 | 8'(n << 2));
      settle(0);
      `CHK(irq[0], n[0])
      apb(1'b0, 8'h56, 8'h00);
      apb(1'b1, 8'h56, 8'h40 | 8'(n << 2));
      port[0] <= 1'b0;
      settle(8);
      `CHK(irq[0], n[1])
    end
    // reading the high value byte holds off captures
    apb(1'b0, 8'h56, 8'h00);
    apb(1'b1, 8'h56, 8'h4c);
    apb(1'b0, 8'h57, 8'h00);
    port[0] <= 1'b1;
    settle(8);
    `CHK(irq[0], 1'b0)
    apb(1'b0, 8'h58, 8'h00);
    port[0] <= 1'b0;
    settle(8);
    `CHK(irq[0], 1'b1)
    $display("capture test done");
    // compare and pwm cases, starting from a preset low level
    apb(1'b1, 8'h51, 8'h30);
    apb(1'b1, 8'h54, 8'h00);
    apb(1'b1, 8'h55, 8'h09);
    apb(1'b1, 8'h56, 8'h10);
    settle(1);
    `CHK(oe[0], 1'b0)
    `CHK(cpin[0], 1'b0)
    apb(1'b1, 8'h51, 8'h00);
    foreach (pw[i]) begin
      apb(1'b1, 8'h57, 8'h00);
      apb(1'b1, 8'h58, pw[i][15:8]);
      apb(1'b1, 8'h56, pw[i][23:16]);
      settle(30);
      `CHK(oe[0], 1'b1)
      k = 0;
      repeat (100) begin
        @(negedge clk);
        k += pin[0];
      end
      `CHK(k + 2 >= pw[i][7:0] && k <= pw[i][7:0] + 2, 1'b1)
    end
    $display("pwm test done");
    // a high value write holds off compare matches
    apb(1'b1, 8'h56, 8'h18);
    settle(30);
    apb(1'b1, 8'h57, 8'h00);
    apb(1'b1, 8'h56, 8'h1c);
    settle(30);
    `CHK(cpin[0], 1'b0)
    apb(1'b1, 8'h58, 8'h03);
    settle(30);
    `CHK(cpin[0], 1'b1)
    $display("hold test done");
    // reset in mid run restores the defaults, from a preset low level
    apb(1'b1, 8'h56, 8'h50);
    settle(1);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    settle(0);
    `CHK(cpin, 2'h3)
    `CHK(irq, 2'h0)
    `CHK(oe, 2'h0)
    apb(1'b0, 8'h51, 8'h00);
    `CHK(rv[7:0], 8'h20)
    apb(1'b0, 8'h53, 8'h00);
    `CHK(rv[7:0], 8'h00)
    apb(1'b0, 8'h55, 8'h00);
    `CHK(rv[7:0], 8'hff)
    $display("reset test done");
    test_done();
  end
endmodule
